// *** verilog/mcvh_channel.sv ***
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module mcvh_channel (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Register port
    input wire logic [mcvh_pkg::ADDR_W-1:0] i_addr,
    input wire logic [mcvh_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [mcvh_pkg::DATA_W-1:0] o_rdata,
    // Module-wide active setting
    input wire logic i_module_active,
    // One pulse per measuring cycle with the sensed resistance
    input wire logic i_meas_valid,
    input wire logic [mcvh_pkg::RES_W-1:0] i_meas_res,
    // Value toward the com unit
    output logic o_value_valid,
    output logic [mcvh_pkg::PTS_W-1:0] o_value,
    output logic o_invalid,
    output logic o_line_fault,
    output logic o_channel_active
);
    import mcvh_pkg::*;

    // Configuration registers
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0] lfd_delay;
    logic [PTS_W-1:0] lim_low;
    logic [PTS_W-1:0] rng_start;
    logic [PTS_W-1:0] rng_end;
    logic [PTS_W-1:0] lim_high;
    logic [FRAC_W-1:0] sim_value;
    logic [FRAC_W-1:0] sub_value;
    logic [RES_W-1:0] lead_res;
    logic [RES_W-1:0] phys_begin;
    logic [GAIN_W-1:0] phys_gain;

    // Channel state
    logic fault_pending;            // Line fault seen, debounce not done
    logic [CNT_W-1:0] clean_cnt;    // Fault-free cycles since last fault, counted while pending
    logic [PTS_W-1:0] last_good;    // Last valid field value in points

    // Decoded control fields
    logic sim_mode;
    logic sim_invalid;
    logic lfd_en;
    mcvh_err_type err_mode;
    mcvh_wire_type wire_mode;

    // Combinational results of this measuring cycle
    logic [RES_W-1:0] res_comp;
    logic fault_now;
    logic err_active;
    logic signed [FRAC_W-1:0] field_frac;
    logic [PTS_W-1:0] field_pts;
    logic [PTS_W-1:0] next_pts;
    logic next_invalid;
    logic next_pending;
    logic [CNT_W-1:0] next_cnt;
    logic [PTS_W-1:0] next_word;
    logic stat_on;

    // Maps a signed range fraction to clamped points
    function automatic logic [PTS_W-1:0] to_points(input logic signed [FRAC_W-1:0] frac);
        logic signed [PTS_W:0] span;
        logic signed [FRAC_W+PTS_W:0] prod;
        logic signed [PTS_W+3:0] pts;
        span = $signed({1'b0, rng_end}) - $signed({1'b0, rng_start});
        prod = frac * span;
        pts = (PTS_W+4)'(prod >>> FRAC_BITS) + $signed({4'h0, rng_start});
        if (pts < $signed({4'h0, lim_low})) begin
            to_points = lim_low;
        end else if (pts > $signed({4'h0, lim_high})) begin
            to_points = lim_high;
        end else begin
            to_points = pts[PTS_W-1:0];
        end
    endfunction

    // Control field decode
    always_comb begin
        sim_mode = ctrl[CTRL_SIM_BIT];
        sim_invalid = ctrl[CTRL_SIM_INV_BIT];
        lfd_en = ctrl[CTRL_LFD_BIT];
        err_mode = mcvh_err_type'(ctrl[CTRL_ERR_MSB:CTRL_ERR_LSB]);
        wire_mode = mcvh_wire_type'(ctrl[CTRL_WIRE_MSB:CTRL_WIRE_LSB]);
    end

    // Wiring compensation and line fault detection
    always_comb begin
        // Lead resistance is removed only in 2-wire, saturating at zero
        if (wire_mode == WIRE_2 && i_meas_res > lead_res) begin
            res_comp = i_meas_res - lead_res;
        end else if (wire_mode == WIRE_2) begin
            res_comp = '0;
        end else begin
            res_comp = i_meas_res;
        end
        // Thresholds judge the raw measured resistance, before lead removal
        fault_now = lfd_en && (i_meas_res > OPEN_RES || i_meas_res < SHORT_RES);
    end

    // Resistance to range fraction, saturated
    always_comb begin
        logic signed [RES_W:0] diff;
        logic signed [RES_W+GAIN_W+1:0] prod;
        logic signed [RES_W+GAIN_W+1:0] frac_full;
        diff = $signed({1'b0, res_comp}) - $signed({1'b0, phys_begin});
        prod = diff * $signed({1'b0, phys_gain});
        frac_full = prod >>> GAIN_BITS;
        if (frac_full > (RES_W+GAIN_W+2)'(FRAC_MAX)) begin
            field_frac = FRAC_MAX;
        end else if (frac_full < (RES_W+GAIN_W+2)'(FRAC_MIN)) begin
            field_frac = FRAC_MIN;
        end else begin
            field_frac = frac_full[FRAC_W-1:0];
        end
        field_pts = to_points(field_frac);
    end

    // Debounce of line faults
    always_comb begin
        next_pending = fault_pending;
        next_cnt = clean_cnt;
        if (!lfd_en) begin
            // No debounce applies with the check switched off
            next_pending = 1'b0;
            next_cnt = '0;
        end else if (fault_now) begin
            // Any fault starts or restarts the fault-free count
            next_pending = 1'b1;
            next_cnt = '0;
        end else if (fault_pending) begin
            if (clean_cnt + 8'h01 >= lfd_delay) begin
                next_pending = 1'b0;
                next_cnt = '0;
            end else begin
                next_cnt = clean_cnt + 8'h01;
            end
        end
        err_active = fault_now || fault_pending;
    end

    // Value selection by operating mode and error strategy
    always_comb begin
        next_pts = field_pts;
        next_invalid = 1'b0;
        if (sim_mode) begin
            next_pts = to_points($signed(sim_value));
            next_invalid = sim_invalid;
        end else if (err_active) begin
            unique case (err_mode)
                ERR_CURRENT: begin
                    next_pts = field_pts;
                    next_invalid = 1'b0;
                end
                ERR_SUBST: begin
                    next_pts = to_points($signed(sub_value));
                    next_invalid = 1'b1;
                end
                ERR_HOLD: begin
                    next_pts = last_good;
                    next_invalid = 1'b1;
                end
                default: begin
                    // Unused code behaves as substitute
                    next_pts = to_points($signed(sub_value));
                    next_invalid = 1'b1;
                end
            endcase
        end
    end

    // Status nibble insertion
    always_comb begin
        stat_on = rng_start >= STAT_WIN_LOW && rng_end <= STAT_WIN_HIGH;
        next_word = next_pts;
        if (stat_on) begin
            next_word[3:0] = '0;
            next_word[STAT_LF_BIT] = err_active;
        end
    end

    // Debounce state, stepped once per measuring cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            fault_pending <= 1'b0;
            clean_cnt <= '0;
        end else if (i_meas_valid && i_module_active) begin
            fault_pending <= next_pending;
            clean_cnt <= next_cnt;
        end else if (!lfd_en) begin
            // Dropping the check clears any debounce at once
            fault_pending <= 1'b0;
            clean_cnt <= '0;
        end
    end

    // Last valid field value for the hold strategy
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            last_good <= RNG_START_RST;
        end else if (i_meas_valid && i_module_active && !err_active) begin
            last_good <= field_pts;
        end
    end

    // Output value toward the com unit
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_value_valid <= 1'b0;
            o_value <= '0;
            o_invalid <= 1'b0;
            o_line_fault <= 1'b0;
        end else begin
            // Inactive channel forwards nothing
            o_value_valid <= i_meas_valid && i_module_active;
            if (i_meas_valid && i_module_active) begin
                o_value <= next_word;
                o_invalid <= next_invalid;
                o_line_fault <= err_active;
            end
        end
    end

    // Channel active mirrors the module-wide setting
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_channel_active <= 1'b0;
        end else begin
            o_channel_active <= i_module_active;
        end
    end

    // Register writes
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctrl <= CTRL_RST;
            lfd_delay <= LFD_DELAY_RST;
            lim_low <= LIM_LOW_RST;
            rng_start <= RNG_START_RST;
            rng_end <= RNG_END_RST;
            lim_high <= LIM_HIGH_RST;
            sim_value <= '0;
            sub_value <= '0;
            lead_res <= '0;
            phys_begin <= PHYS_BEGIN_RST;
            phys_gain <= PHYS_GAIN_RST;
        end else if (i_wr) begin
            unique case (i_addr)
                REG_CTRL: ctrl <= i_wdata[CTRL_W-1:0];
                REG_LFD_DELAY: lfd_delay <= i_wdata[CNT_W-1:0];
                REG_LIM_LOW: lim_low <= i_wdata[PTS_W-1:0];
                REG_RNG_START: rng_start <= i_wdata[PTS_W-1:0];
                REG_RNG_END: rng_end <= i_wdata[PTS_W-1:0];
                REG_LIM_HIGH: lim_high <= i_wdata[PTS_W-1:0];
                REG_SIM_VALUE: sim_value <= i_wdata[FRAC_W-1:0];
                REG_SUB_VALUE: sub_value <= i_wdata[FRAC_W-1:0];
                REG_LEAD_RES: lead_res <= i_wdata[RES_W-1:0];
                REG_PHYS_BEGIN: phys_begin <= i_wdata[RES_W-1:0];
                REG_PHYS_GAIN: phys_gain <= i_wdata[GAIN_W-1:0];
                // Read-only and unmapped writes are ignored
                default: begin
                end
            endcase
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                REG_CTRL: o_rdata <= DATA_W'(ctrl);
                REG_LFD_DELAY: o_rdata <= DATA_W'(lfd_delay);
                REG_LIM_LOW: o_rdata <= DATA_W'(lim_low);
                REG_RNG_START: o_rdata <= DATA_W'(rng_start);
                REG_RNG_END: o_rdata <= DATA_W'(rng_end);
                REG_LIM_HIGH: o_rdata <= DATA_W'(lim_high);
                REG_SIM_VALUE: o_rdata <= DATA_W'(sim_value);
                REG_SUB_VALUE: o_rdata <= DATA_W'(sub_value);
                REG_LEAD_RES: o_rdata <= DATA_W'(lead_res);
                REG_PHYS_BEGIN: o_rdata <= DATA_W'(phys_begin);
                REG_PHYS_GAIN: o_rdata <= DATA_W'(phys_gain);
                // Live channel state
                REG_STATUS: o_rdata <= {16'h0000, clean_cnt, 4'h0,
                    o_channel_active, o_invalid, o_line_fault, fault_pending};
                REG_VALUE: o_rdata <= DATA_W'(o_value);
                // Unmapped addresses read zero
                default: o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

endmodule // mcvh_channel

`default_nettype wire

// *** verilog/mcvh_pkg.sv ***
// Shared constants for the measurement channel value handler
package mcvh_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Register indices on the plain register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_LFD_DELAY = 4'h1;
    localparam logic [3:0] REG_LIM_LOW = 4'h2;
    localparam logic [3:0] REG_RNG_START = 4'h3;
    localparam logic [3:0] REG_RNG_END = 4'h4;
    localparam logic [3:0] REG_LIM_HIGH = 4'h5;
    localparam logic [3:0] REG_SIM_VALUE = 4'h6;
    localparam logic [3:0] REG_SUB_VALUE = 4'h7;
    localparam logic [3:0] REG_LEAD_RES = 4'h8;
    localparam logic [3:0] REG_PHYS_BEGIN = 4'h9;
    localparam logic [3:0] REG_PHYS_GAIN = 4'ha;
    localparam logic [3:0] REG_STATUS = 4'hb;
    localparam logic [3:0] REG_VALUE = 4'hc;

    // Control register field positions
    localparam int CTRL_SIM_BIT = 0;
    localparam int CTRL_ERR_LSB = 1;
    localparam int CTRL_ERR_MSB = 2;
    localparam int CTRL_LFD_BIT = 3;
    localparam int CTRL_WIRE_LSB = 4;
    localparam int CTRL_WIRE_MSB = 5;
    localparam int CTRL_SIM_INV_BIT = 6;
    localparam int CTRL_W = 7;

    // Field widths
    localparam int RES_W = 20;      // Resistance in units of 0.01 ohm
    localparam int FRAC_W = 18;     // Signed fraction of range, 1.0 = 2**FRAC_BITS
    localparam int FRAC_BITS = 16;
    localparam int GAIN_W = 26;     // Fraction per 0.01 ohm, scaled by 2**GAIN_BITS
    localparam int GAIN_BITS = 24;
    localparam int PTS_W = 16;
    localparam int CNT_W = 8;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h08;
    localparam logic [CNT_W-1:0] LFD_DELAY_RST = 8'h0a;
    localparam logic [PTS_W-1:0] LIM_LOW_RST = 16'h0000;
    localparam logic [PTS_W-1:0] RNG_START_RST = 16'h2710;
    localparam logic [PTS_W-1:0] RNG_END_RST = 16'hc350;
    localparam logic [PTS_W-1:0] LIM_HIGH_RST = 16'hea60;
    localparam logic [RES_W-1:0] PHYS_BEGIN_RST = 20'h00000;
    localparam logic [GAIN_W-1:0] PHYS_GAIN_RST = 26'h1a36e2f;

    // Line fault thresholds in 0.01 ohm: open above 1 kohm, short below 10 ohm
    localparam logic [RES_W-1:0] OPEN_RES = 20'h186a0;
    localparam logic [RES_W-1:0] SHORT_RES = 20'h003e8;

    // Status nibble is carried only when scaling lies inside this window
    localparam logic [PTS_W-1:0] STAT_WIN_LOW = 16'h2710;
    localparam logic [PTS_W-1:0] STAT_WIN_HIGH = 16'hc350;
    localparam int STAT_LF_BIT = 1;

    // Fraction saturation bounds
    localparam logic signed [FRAC_W-1:0] FRAC_MAX = 18'sh1ffff;
    localparam logic signed [FRAC_W-1:0] FRAC_MIN = -18'sh20000;

    // Error strategy
    typedef enum logic [1:0] {ERR_CURRENT, ERR_SUBST, ERR_HOLD} mcvh_err_type;

    // Sensor wiring method
    typedef enum logic [1:0] {WIRE_2, WIRE_3, WIRE_4} mcvh_wire_type;

endpackage

// *** bench/mcvh_channel_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcvh_channel_chk
    import mcvh_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [mcvh_pkg::ADDR_W-1:0] i_addr,
    input wire logic [mcvh_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [mcvh_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_module_active,
    input wire logic i_meas_valid,
    input wire logic [mcvh_pkg::RES_W-1:0] i_meas_res,
    input wire logic o_value_valid,
    input wire logic [mcvh_pkg::PTS_W-1:0] o_value,
    input wire logic o_invalid,
    input wire logic o_line_fault,
    input wire logic o_channel_active
);
    logic [CTRL_W-1:0] ctl; // Shadow of the control word
    logic [PTS_W-1:0] pts [2:5]; // Shadow of limits and range points
    logic acc; // Measurement taken at this edge
    logic flt; // Raw line fault on that sample
    logic win; // Status nibble replaces the low bits
    logic [1:0] strat; // Shadowed error strategy
    assign acc = i_meas_valid && i_module_active;
    assign flt = ctl[CTRL_LFD_BIT] && (i_meas_res > OPEN_RES || i_meas_res < SHORT_RES);
    assign win = pts[3] >= STAT_WIN_LOW && pts[4] <= STAT_WIN_HIGH;
    assign strat = ctl[CTRL_ERR_MSB:CTRL_ERR_LSB];
    // Follow control writes
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctl <= CTRL_RST;
        end else if (i_wr && i_addr == REG_CTRL) begin
            ctl <= i_wdata[CTRL_W-1:0];
        end
    end
    // Follow writes to the four points settings
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pts[2] <= LIM_LOW_RST;
            pts[3] <= RNG_START_RST;
            pts[4] <= RNG_END_RST;
            pts[5] <= LIM_HIGH_RST;
        end else if (i_wr && i_addr >= REG_LIM_LOW && i_addr <= REG_LIM_HIGH) begin
            pts[i_addr] <= i_wdata[PTS_W-1:0];
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    chk_value_follows: assert property (acc |=> o_value_valid)
        else $error("no value after a taken measurement");
    chk_idle_quiet: assert property (!acc |=> !o_value_valid)
        else $error("value without an active measurement");
    chk_active_copy: assert property (1'b1 |=> o_channel_active == $past(i_module_active))
        else $error("channel active does not follow module active");
    chk_value_holds: assert property (!o_value_valid |-> $stable(o_value))
        else $error("value moved between measurements");
    chk_fault_flag: assert property (acc && flt |=> o_line_fault)
        else $error("line fault not flagged");
    chk_no_debounce: assert property (acc && !ctl[CTRL_LFD_BIT] |=> !o_line_fault)
        else $error("line fault with detection off");
    chk_subst_invalid: assert property (acc && flt && !ctl[0] && strat != 2'h0 |=> o_invalid)
        else $error("replacement value not marked invalid");
    chk_current_plain: assert property (acc && !ctl[0] && strat == 2'h0 |=> !o_invalid)
        else $error("current value marked invalid");
    chk_sim_status: assert property (acc && ctl[0] |=> o_invalid == $past(ctl[CTRL_SIM_INV_BIT]))
        else $error("simulated status wrong");
    chk_limits_held: assert property (o_value_valid && !win |-> o_value >= pts[2] && o_value <= pts[5])
        else $error("value outside limits");
    chk_status_nibble: assert property (o_value_valid && win |-> o_value[3:0] == {2'b00, o_line_fault, 1'b0})
        else $error("status nibble wrong");
endmodule // mcvh_channel_chk
bind mcvh_channel mcvh_channel_chk i_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_module_active(i_module_active), .i_meas_valid(i_meas_valid), .i_meas_res(i_meas_res),
    .o_value_valid(o_value_valid), .o_value(o_value), .o_invalid(o_invalid),
    .o_line_fault(o_line_fault), .o_channel_active(o_channel_active));
`default_nettype wire

// *** bench/mcvh_com_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcvh_com_unit (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_value_valid,
    input wire logic [15:0] i_value,
    input wire logic i_invalid,
    output logic [15:0] o_frames,
    output logic [15:0] o_value,
    output logic o_invalid
);
    // Take each forwarded word with its status beside it
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_frames <= 16'h0000;
            o_value <= 16'h0000;
            o_invalid <= 1'b0;
        end else if (i_value_valid) begin
            o_frames <= o_frames + 16'h0001;
            o_value <= i_value;
            o_invalid <= i_invalid;
        end
    end
endmodule // mcvh_com_unit
`default_nettype wire

// *** bench/mcvh_channel_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcvh_channel_tb_top;
    import mcvh_pkg::*;
    logic i_clk_sys, i_rst_n, i_wr, i_rd, i_module_active, i_meas_valid;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [19:0] i_meas_res;
    logic o_value_valid, o_invalid, o_line_fault, o_channel_active, com_inv;
    logic [15:0] o_value, frames, com_value, expv, lastv;
    logic [31:0] seed = 32'h35bc; // Fixed random seed
    logic [31:0] mir [0:15]; // Mirror of written settings
    logic pend; // Debounce pending in the model
    int cnt, errors, total_checks, cyc, sent;
    mcvh_channel i_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_module_active(i_module_active), .i_meas_valid(i_meas_valid),
        .i_meas_res(i_meas_res), .o_value_valid(o_value_valid), .o_value(o_value),
        .o_invalid(o_invalid), .o_line_fault(o_line_fault), .o_channel_active(o_channel_active));
    mcvh_com_unit i_com (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_value_valid(o_value_valid),
        .i_value(o_value), .i_invalid(o_invalid), .o_frames(frames), .o_value(com_value),
        .o_invalid(com_inv));
    // Clock at 4 ns
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Fraction of range to clamped points
    function automatic longint scl(longint f);
        longint p;
        f = (f > 131071) ? 131071 : ((f < -131072) ? -131072 : f);
        // Scaling floors toward minus infinity, as an arithmetic shift does
        p = longint'(mir[3][15:0]) + ((f * (longint'(mir[4][15:0]) - longint'(mir[3][15:0]))) >>> 16);
        if (p < longint'(mir[2][15:0])) p = longint'(mir[2][15:0]);
        if (p > longint'(mir[5][15:0])) p = longint'(mir[5][15:0]);
        return p;
    endfunction
    task automatic predict(input logic [19:0] res, output logic [15:0] v, output logic inv,
        output logic lf);
        logic flt, was;
        longint r, fld;
        flt = mir[0][3] && (res > OPEN_RES || res < SHORT_RES);
        if (!mir[0][3]) pend = 1'b0;
        // Error seen by this sample uses the pending state before it
        was = pend;
        if (flt) begin
            pend = 1'b1;
            cnt = 0;
        end else if (pend) begin
            cnt++;
            if (cnt >= ((mir[1][7:0] == 8'h00) ? 1 : int'(mir[1][7:0]))) pend = 1'b0;
        end
        r = longint'(res) - ((mir[0][5:4] == 2'h0) ? longint'(mir[8][19:0]) : 0);
        if (r < 0) r = 0;
        fld = scl(((r - longint'(mir[9][19:0])) * longint'(mir[10][25:0])) >>> 24);
        lf = flt | was;
        inv = 1'b0;
        v = 16'(fld);
        if (mir[0][0]) begin
            v = 16'(scl(longint'($signed(mir[6][17:0]))));
            inv = mir[0][6];
        end else if (lf && mir[0][2:1] == 2'h2) begin
            v = expv;
            inv = 1'b1;
        end else if (lf && mir[0][2:1] != 2'h0) begin
            v = 16'(scl(longint'($signed(mir[7][17:0]))));
            inv = 1'b1;
        end
        if (!lf) expv = 16'(fld);
        if (mir[3][15:0] >= 16'h2710 && mir[4][15:0] <= 16'hc350) v[3:0] = {2'b00, lf, 1'b0};
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        mir[a] = d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic meas(input logic [19:0] res);
        logic [15:0] v;
        logic inv, lf;
        predict(res, v, inv, lf);
        lastv = v;
        @(posedge i_clk_sys);
        i_meas_valid <= 1'b1;
        i_meas_res <= res;
        @(posedge i_clk_sys);
        i_meas_valid <= 1'b0;
        #1 sent++;
        check(32'(o_value_valid), 32'h1, "valid");
        check(32'(o_value), 32'(v), "value");
        check({30'h0, o_invalid, o_line_fault}, {30'h0, inv, lf}, "status");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end
    initial begin
        logic [31:0] x, d;
        {i_rst_n, i_wr, i_rd, i_meas_valid, i_addr, i_wdata, i_meas_res} = '0;
        i_module_active = 1'b1;
        pend = 1'b0;
        expv = 16'h2710;
        for (int k = 0; k < 16; k++) mir[k] = 32'h0;
        {mir[0], mir[1], mir[3], mir[4], mir[5]} = {32'h8, 32'ha, 32'h2710, 32'hc350, 32'hea60};
        mir[10] = 32'h1a36e2f;
        repeat (8) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        // Reset values, unmapped indices read zero
        for (int a = 0; a < 16; a++) begin
            if (a != 11 && a != 12) begin
                rd(4'(a), d);
                check(d, mir[a], "reset");
            end
        end
        $display("test reset done");
        // Strategies and wiring in turn, random modes over clamped scaling
        {mir[9], mir[10]} = {32'h4e20, 32'h1000000};
        wr(REG_PHYS_GAIN, mir[10]);
        wr(REG_PHYS_BEGIN, mir[9]);
        wr(REG_LIM_LOW, 32'h2328);
        wr(REG_RNG_START, 32'h2000);
        wr(REG_RNG_END, 32'h6000);
        wr(REG_LIM_HIGH, 32'h4e20);
        for (int s = 0; s < 8; s++) begin
            x = rnd();
            wr(REG_CTRL, {25'h0, x[6], 2'(s % 3), !s[2] | x[3], 2'(s % 4), s[2] & x[0]});
            wr(REG_LFD_DELAY, {29'h0, x[12:10]});
            wr(REG_SIM_VALUE, {14'h0, x[31:16], 2'b00});
            wr(REG_SUB_VALUE, {14'h0, x[27:12], 2'b00});
            wr(REG_LEAD_RES, {22'h0, x[7:0], 2'b00});
            foreach (mir[k]) if (k == 0) meas(20'h186a0);
            meas(20'h186a4);
            meas(20'h003e8);
            meas(20'h003e4);
            for (int n = 0; n < 30; n++) begin
                x = rnd();
                meas({3'h0, x[16:2], 2'b00});
            end
        end
        $display("test strategies done");
        // Debounce restart with the status nibble in use
        wr(REG_CTRL, 32'h18);
        wr(REG_LFD_DELAY, 32'h3);
        wr(REG_PHYS_BEGIN, 32'h0);
        wr(REG_RNG_START, 32'h2710);
        wr(REG_RNG_END, 32'hc350);
        wr(REG_LIM_LOW, 32'h0);
        wr(REG_LIM_HIGH, 32'hea60);
        foreach (mir[k]) if (k < 8) meas((k == 0 || k == 3) ? 20'h0 : 20'h5000);
        $display("test debounce done");
        // Inactive module refuses measurements
        @(posedge i_clk_sys);
        i_module_active <= 1'b0;
        i_meas_valid <= 1'b1;
        i_meas_res <= 20'h5000;
        @(posedge i_clk_sys);
        i_meas_valid <= 1'b0;
        #1 check(32'(o_value_valid), 32'h0, "refused");
        check(32'(o_channel_active), 32'h0, "active");
        check(32'(o_value), 32'(lastv), "value kept");
        @(posedge i_clk_sys);
        i_module_active <= 1'b1;
        rd(REG_VALUE, d);
        check(d, 32'(lastv), "value reg");
        @(posedge i_clk_sys);
        check(32'(frames), 32'(sent), "frames");
        $display("test inactive done");
        tally_and_finish();
    end
endmodule // mcvh_channel_tb_top
`default_nettype wire
